/* File: host_model.sv */
// host processor model driving byte pairs on the port pins
`timescale 1ns/10ps
module host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] bus_in,
	input  wire logic       ready_in,
	output logic            cs_n_out = 1'b1,
	output logic [1:0]      sel_out = 2'h0,
	output logic            rnw_out = 1'b1,
	output logic            half_out = 1'b0,
	output logic            stb_n_out = 1'b1,
	output logic [7:0]      hd_out
);
	logic [7:0] hd_r = 8'h00;
	logic       drv_r = 1'b0;
	logic [7:0] last_r = 8'h00;
	// a released bus alternates each cycle between the inverse of the last byte and the last byte
	assign hd_out = drv_r ? hd_r : ~last_r;
	always @(posedge clk_in) last_r <= hd_out;
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : step
	task automatic xfer(input logic [1:0] sel, input logic rd,
		input logic [7:0] b0, b1, output logic [15:0] w, output logic wt,
		output logic ok);
		int i;
		step(1);
		cs_n_out = 1'b0;
		sel_out = sel;
		rnw_out = rd;
		for (int h = 0; h < 2; h++) begin
			half_out = h[0];
			hd_r = h[0] ? b1 : b0;
			drv_r = !rd;
			step(2);
			stb_n_out = 1'b0;
			step(5);
			w = {w[7:0], bus_in};
			stb_n_out = 1'b1;
			step(4);
			drv_r = 1'b0;
		end
		wt = !ready_in;
		i = 0;
		while (!ready_in && i < 30) begin
			step(1);
			i++;
		end
		ok = ready_in;
		cs_n_out = 1'b1;
		step(4);
	endtask : xfer
	// one write strobe that ignores ready, to probe refusal while busy;
	// bus is left driven so back-to-back calls never toggle it in a step
	task automatic poke(input logic [1:0] sel, input logic h,
		input logic [7:0] b);
		cs_n_out = 1'b0;
		sel_out = sel;
		rnw_out = 1'b0;
		half_out = h;
		hd_r = b;
		drv_r = 1'b1;
		step(1);
		stb_n_out = 1'b0;
		step(1);
		stb_n_out = 1'b1;
		step(3);
	endtask : poke
endmodule : host_model

/* File: host_port.sv */
// device side of the byte-wide host port with its dual-access memory
`timescale 1ns/10ps
module host_port #(
	parameter int ADDR_W = 11
) (
	input  wire logic               clk_in,
	input  wire logic               reset_in,
	input  wire logic               port_chip_select_n_in,
	input  wire logic [1:0]         access_target_select_in,
	input  wire logic               port_read_not_write_in,
	input  wire logic               byte_half_select_in,
	input  wire logic               port_data_strobe_n_in,
	input  wire logic [7:0]         port_byte_bus_in,
	output logic      [7:0]         port_byte_bus_out,
	output logic                    port_byte_bus_oe_n_out,
	output logic                    port_ready_out,
	output logic                    core_to_host_interrupt_n_out,
	input  wire logic               core_ctrl_wr_in,
	input  wire logic [15:0]        core_ctrl_wdata_in,
	output logic      [15:0]        core_ctrl_rdata_out,
	output logic                    host_to_core_interrupt_out,
	output logic                    shared_mode_flag_out,
	input  wire logic               core_mem_wr_in,
	input  wire logic [ADDR_W-1:0]  core_mem_addr_in,
	input  wire logic [15:0]        core_mem_wdata_in,
	output logic      [15:0]        core_mem_rdata_out
);
	import host_port_pkg::*;

	localparam int PIN_W = 14;
	localparam int CNT_W = $clog2(BUSY_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BUSY_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	logic [15:0] mem [0:(1<<ADDR_W)-1];

	// pin synchronisers; stage one feeds only stage two
	logic [PIN_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
	logic             strobe_end;
	logic             cs_n_q, rnw_q, half_q, strobe_n_q, cs_n_s2;
	logic             rnw_s2, half_s2, strobe_n_s2;
	logic [1:0]       sel_q, sel_s2;
	logic [7:0]       din_q;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pin_s1_r <= {PIN_W{1'b1}};
			pin_s2_r <= {PIN_W{1'b1}};
			pin_s3_r <= {PIN_W{1'b1}};
		end else begin
			pin_s1_r <= {port_chip_select_n_in, access_target_select_in,
				port_read_not_write_in, byte_half_select_in,
				port_data_strobe_n_in, port_byte_bus_in};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	// controls and data taken one stage later than the strobe edge,
	// so a host that drops controls with the strobe is still seen
	assign {cs_n_q, sel_q, rnw_q, half_q, strobe_n_q, din_q} = pin_s3_r;
	assign {cs_n_s2, sel_s2, rnw_s2, half_s2, strobe_n_s2} =
		pin_s2_r[PIN_W-1:8];
	assign strobe_end = strobe_n_s2 && !strobe_n_q;

	// control, address, latches and transfer engine
	xfer_state_t       state_r, state_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic              op_read_r, op_read_nxt;
	logic              op_mem_r, op_mem_nxt;
	logic [15:0]       addr_r, addr_nxt;
	logic [7:0]        addr_first_r, addr_first_nxt;
	logic [7:0]        latch1_r, latch1_nxt;
	logic [7:0]        latch2_r, latch2_nxt;
	logic              order_r, order_nxt;
	logic              shared_r, shared_nxt;
	logic              core_to_host_interrupt_r, core_to_host_interrupt_nxt;
	logic              core_int_r, core_int_nxt;
	logic              taken, launch;
	logic [15:0]       addr_asm, data_word, mem_word;
	logic              mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [15:0]       mem_wdata;

	assign taken    = strobe_end && !cs_n_q && state_r == st_idle;
	assign addr_asm = order_r ? {din_q, addr_first_r}
		: {addr_first_r, din_q};
	assign mem_word = mem[addr_r[ADDR_W-1:0]];

	always_comb begin
		state_nxt      = state_r;
		cnt_nxt        = cnt_r;
		op_read_nxt    = op_read_r;
		op_mem_nxt     = op_mem_r;
		addr_nxt       = addr_r;
		addr_first_nxt = addr_first_r;
		latch1_nxt     = latch1_r;
		latch2_nxt     = latch2_r;
		order_nxt      = order_r;
		shared_nxt     = shared_r;
		core_to_host_interrupt_nxt       = core_to_host_interrupt_r;
		core_int_nxt   = 1'b0;
		launch         = 1'b0;
		mem_we         = 1'b0;
		mem_waddr      = addr_r[ADDR_W-1:0];
		data_word      = order_r ? {latch2_r, latch1_r}
			: {latch1_r, latch2_r};

		if (taken) begin
			case (sel_q)
				SEL_CONTROL: begin
					// applied on the second byte; both bytes carry the same value
					if (!rnw_q && half_q) begin
						order_nxt = din_q[BIT_BYTE_ORDER];
						if (din_q[BIT_HOST_INT])
							core_to_host_interrupt_nxt = 1'b0;
						if (din_q[BIT_CORE_INT])
							core_int_nxt = 1'b1;
						launch = din_q[BIT_HOST_INT] || din_q[BIT_CORE_INT];
						op_mem_nxt = 1'b0;
					end
				end
				SEL_ADDRESS: begin
					if (!rnw_q) begin
						if (!half_q) begin
							addr_first_nxt = din_q;
						end else begin
							addr_nxt    = addr_asm;
							launch      = 1'b1;
							op_read_nxt = 1'b1;
							op_mem_nxt  = 1'b1;
						end
					end
				end
				default: begin
					if (!rnw_q) begin
						if (!half_q)
							latch1_nxt = din_q;
						else
							latch2_nxt = din_q;
					end
					if (half_q) begin
						launch      = 1'b1;
						op_read_nxt = rnw_q;
						op_mem_nxt  = 1'b1;
						if (sel_q == SEL_DATA_INC)
							addr_nxt = addr_r + ADDR_STEP;
					end
				end
			endcase
		end

		// a plain control write without interrupt bits never launches
		if (launch) begin
			state_nxt = st_busy;
			cnt_nxt   = '0;
		end

		if (state_r == st_busy) begin
			if (cnt_r == CNT_LAST) begin
				state_nxt = st_idle;
				// kind of transfer kept from launch, not from the select
				// pins, which a deselected host may already have moved
				if (op_mem_r && op_read_r) begin
					latch1_nxt = order_r ? mem_word[7:0] : mem_word[15:8];
					latch2_nxt = order_r ? mem_word[15:8] : mem_word[7:0];
				end else if (op_mem_r) begin
					mem_we = 1'b1;
				end
			end else begin
				cnt_nxt = cnt_r + CNT_ONE;
			end
		end

		if (core_ctrl_wr_in) begin
			shared_nxt = core_ctrl_wdata_in[BIT_SHARED];
			if (core_ctrl_wdata_in[BIT_HOST_INT])
				core_to_host_interrupt_nxt = 1'b1;
		end
		mem_wdata = data_word;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_r      <= st_idle;
			cnt_r        <= '0;
			op_read_r    <= 1'b1;
			op_mem_r     <= 1'b0;
			addr_r       <= '0;
			addr_first_r <= '0;
			latch1_r     <= '0;
			latch2_r     <= '0;
			order_r      <= 1'b0;
			shared_r     <= 1'b0;
			core_to_host_interrupt_r       <= 1'b0;
			core_int_r   <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			cnt_r        <= cnt_nxt;
			op_read_r    <= op_read_nxt;
			op_mem_r     <= op_mem_nxt;
			addr_r       <= addr_nxt;
			addr_first_r <= addr_first_nxt;
			latch1_r     <= latch1_nxt;
			latch2_r     <= latch2_nxt;
			order_r      <= order_nxt;
			shared_r     <= shared_nxt;
			core_to_host_interrupt_r       <= core_to_host_interrupt_nxt;
			core_int_r   <= core_int_nxt;
		end
	end

	// host write wins the memory port; a core write in the same
	// cycle is dropped, the host sees its own word back
	always_ff @(posedge clk_in) begin
		if (mem_we)
			mem[mem_waddr] <= mem_wdata;
		else if (core_mem_wr_in)
			mem[core_mem_addr_in] <= core_mem_wdata_in;
		core_mem_rdata_out <= mem[core_mem_addr_in];
	end

	// host read bus, registered
	logic [7:0] rd_byte, rd_byte_r;
	logic [7:0] ctrl_byte;
	logic       drive_r, drive_nxt;

	assign ctrl_byte = {4'h0, core_to_host_interrupt_r, 1'b0, shared_r, order_r};

	always_comb begin
		case (sel_s2)
			SEL_CONTROL: rd_byte = ctrl_byte;
			SEL_ADDRESS: rd_byte = (half_s2 ^ order_r) ? addr_r[7:0]
				: addr_r[15:8];
			default:     rd_byte = half_s2 ? latch2_r : latch1_r;
		endcase
		drive_nxt = !cs_n_s2 && rnw_s2 && !strobe_n_s2;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rd_byte_r <= '0;
			drive_r   <= 1'b0;
		end else begin
			rd_byte_r <= rd_byte;
			drive_r   <= drive_nxt;
		end
	end

	assign port_byte_bus_out      = rd_byte_r;
	assign port_byte_bus_oe_n_out = !drive_r;
	assign port_ready_out = cs_n_s2 || state_r == st_idle;
	assign core_to_host_interrupt_n_out = !core_to_host_interrupt_r;
	assign core_ctrl_rdata_out = {12'h000, core_to_host_interrupt_r, 1'b0, shared_r, 1'b0};
	assign host_to_core_interrupt_out = core_int_r;
	assign shared_mode_flag_out = shared_r;

endmodule : host_port

/* File: host_port_chk.sv */
// pin-level assertions for the byte-wide host port
`timescale 1ns/10ps
module host_port_chk (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        port_chip_select_n_in,
	input  wire logic        port_read_not_write_in,
	input  wire logic        port_byte_bus_oe_n_out,
	input  wire logic        port_ready_out,
	input  wire logic        core_to_host_interrupt_n_out,
	input  wire logic        core_ctrl_wr_in,
	input  wire logic [15:0] core_ctrl_wdata_in,
	input  wire logic [15:0] core_ctrl_rdata_out,
	input  wire logic        host_to_core_interrupt_out,
	input  wire logic        shared_mode_flag_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_ready_cs_idle: assert property (
		port_chip_select_n_in && $past(port_chip_select_n_in) &&
		$past(port_chip_select_n_in, 2) |-> port_ready_out)
		else $error("ready low while deselected");
	a_busy_five: assert property (
		$fell(port_ready_out) |-> !port_ready_out [*5] ##1 port_ready_out)
		else $error("ready low time wrong");
	a_oe_on_read: assert property (
		!port_byte_bus_oe_n_out |-> $past(port_read_not_write_in, 3) &&
		!$past(port_chip_select_n_in, 3))
		else $error("bus driven outside a read");
	a_core_to_host_interrupt_set: assert property (
		core_ctrl_wr_in && core_ctrl_wdata_in[3] |=>
		!core_to_host_interrupt_n_out)
		else $error("host interrupt pin not low");
	a_core_read: assert property (
		core_ctrl_rdata_out == {12'h000, !core_to_host_interrupt_n_out,
		1'b0, shared_mode_flag_out, 1'b0})
		else $error("core control read wrong");
	a_shared_wr: assert property (
		core_ctrl_wr_in |=> shared_mode_flag_out == $past(core_ctrl_wdata_in[1]))
		else $error("shared flag not taken");
	a_pulse_one: assert property (
		host_to_core_interrupt_out |=> !host_to_core_interrupt_out)
		else $error("core interrupt longer than one cycle");
	a_reset_vals: assert property (
		$fell(reset_in) |-> port_ready_out && core_to_host_interrupt_n_out &&
		port_byte_bus_oe_n_out)
		else $error("wrong values out of reset");
endmodule : host_port_chk
bind host_port host_port_chk chk (
	.clk_in                       (clk_in),
	.reset_in                     (reset_in),
	.port_chip_select_n_in        (port_chip_select_n_in),
	.port_read_not_write_in       (port_read_not_write_in),
	.port_byte_bus_oe_n_out       (port_byte_bus_oe_n_out),
	.port_ready_out               (port_ready_out),
	.core_to_host_interrupt_n_out (core_to_host_interrupt_n_out),
	.core_ctrl_wr_in              (core_ctrl_wr_in),
	.core_ctrl_wdata_in           (core_ctrl_wdata_in),
	.core_ctrl_rdata_out          (core_ctrl_rdata_out),
	.host_to_core_interrupt_out   (host_to_core_interrupt_out),
	.shared_mode_flag_out         (shared_mode_flag_out)
);

/* File: host_port_pkg.sv */
// constants and field layout for the byte-wide host port
// Function
// - host control read: int, zero, shared, order
// - host control write: int clear, core int, order
// - core control read: int, shared, rest zero
// - core control write: only int and shared
// - host uses byte pairs, core uses words
// - address write or data access starts transfer
// - data read returns prefetch, launches next read
// - written data reaches memory after the access
// - ready low while internal transfer runs
// - ready low about five core cycles after access
// - ready high whenever chip select inactive
// - wait states only for listed access kinds; code also waits after a host control write with int clear or core int set
// - address write prefetches word into latches
// - byte half selects latch on read bus
// - autoincrement read bumps address, fetches again
// - select code picks control, data, address
// - byte order sets first byte significance
// - host writing core int pulses core interrupt
// - core sets host int, host clears it
package host_port_pkg;

	localparam logic [1:0] SEL_CONTROL  = 2'h0;
	localparam logic [1:0] SEL_DATA_INC = 2'h1;
	localparam logic [1:0] SEL_ADDRESS  = 2'h2;
	localparam logic [1:0] SEL_DATA     = 2'h3;

	localparam int BIT_BYTE_ORDER = 0;
	localparam int BIT_SHARED     = 1;
	localparam int BIT_CORE_INT   = 2;
	localparam int BIT_HOST_INT   = 3;

	// internal transfer length in core clock cycles
	localparam int BUSY_CYCLES = 5;

	localparam logic [15:0] ADDR_STEP = 16'h0001;

	typedef enum logic {st_idle, st_busy} xfer_state_t;

endpackage : host_port_pkg

/* File: host_port_tb_top.sv */
// self-checking testbench for the byte-wide host port
`timescale 1ns/10ps
module host_port_tb_top;
	import host_port_pkg::*;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        cs_n, rnw, half, stb_n, oe_n, ready, int_n, pulse, shared;
	logic [1:0]  sel;
	logic [7:0]  hd, bus_out;
	logic        cwr = 1'b0;
	logic        mwr = 1'b0;
	logic [15:0] cwd = 16'h0000;
	logic [15:0] mwd = 16'h0000;
	logic [10:0] madr = 11'h000;
	logic [15:0] crd, mrd, w;
	logic        wt;
	int          mismatches = 0;
	int          n_tests = 0;
	int          pulses = 0;
	initial forever #10 clk_in = ~clk_in;
	always @(posedge clk_in) if (pulse === 1'b1) pulses++;
	host_port uut (.clk_in(clk_in), .reset_in(reset_in),
		.port_chip_select_n_in(cs_n), .access_target_select_in(sel),
		.port_read_not_write_in(rnw), .byte_half_select_in(half),
		.port_data_strobe_n_in(stb_n), .port_byte_bus_in(hd),
		.port_byte_bus_out(bus_out), .port_byte_bus_oe_n_out(oe_n),
		.port_ready_out(ready), .core_to_host_interrupt_n_out(int_n),
		.core_ctrl_wr_in(cwr), .core_ctrl_wdata_in(cwd),
		.core_ctrl_rdata_out(crd), .host_to_core_interrupt_out(pulse),
		.shared_mode_flag_out(shared), .core_mem_wr_in(mwr),
		.core_mem_addr_in(madr), .core_mem_wdata_in(mwd),
		.core_mem_rdata_out(mrd));
	host_model host (.clk_in(clk_in), .bus_in(oe_n ? hd : bus_out),
		.ready_in(ready), .cs_n_out(cs_n), .sel_out(sel), .rnw_out(rnw),
		.half_out(half), .stb_n_out(stb_n), .hd_out(hd));
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task automatic check(input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask : tick
	task automatic hx(input logic [1:0] s, input logic rd,
		input logic [7:0] b0, b1);
		logic ok;
		host.xfer(s, rd, b0, b1, w, wt, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			results();
		end
	endtask : hx
	task automatic cw(input logic [15:0] d);
		cwd = d;
		cwr = 1'b1;
		tick();
		cwr = 1'b0;
		tick();
	endtask : cw
	task automatic cm(input logic [10:0] a, input logic [15:0] d);
		madr = a;
		mwd = d;
		mwr = 1'b1;
		tick();
		mwr = 1'b0;
		tick();
	endtask : cm
	task automatic s_control;
		hx(SEL_CONTROL, 1'b0, 8'h01, 8'h01);
		check({15'h0, wt}, 16'h0000);
		hx(SEL_CONTROL, 1'b1, 8'h00, 8'h00);
		check(w, 16'h0101);
		check({15'h0, wt}, 16'h0000);
		cw(16'hFFFA);
		check(crd, 16'h000A);
		check({15'h0, int_n}, 16'h0000);
		hx(SEL_CONTROL, 1'b1, 8'h00, 8'h00);
		check(w, 16'h0B0B);
		hx(SEL_CONTROL, 1'b0, 8'h09, 8'h09);
		check({15'h0, int_n}, 16'h0001);
		check({15'h0, wt}, 16'h0001);
		hx(SEL_CONTROL, 1'b0, 8'h05, 8'h05);
		check(pulses[15:0], 16'h0001);
	endtask : s_control
	task automatic s_memory;
		cm(11'h010, 16'h1234);
		cm(11'h011, 16'hABCD);
		cm(11'h013, 16'h9A5E);
		hx(SEL_ADDRESS, 1'b0, 8'h10, 8'h00);
		check({15'h0, wt}, 16'h0001);
		hx(SEL_DATA_INC, 1'b1, 8'h00, 8'h00);
		check(w, 16'h3412);
		check({15'h0, wt}, 16'h0001);
		hx(SEL_DATA, 1'b1, 8'h00, 8'h00);
		check(w, 16'hCDAB);
		hx(SEL_DATA, 1'b1, 8'h00, 8'h00);
		check(w, 16'hCDAB);
	endtask : s_memory
	task automatic s_write;
		hx(SEL_DATA_INC, 1'b0, 8'h78, 8'h56);
		hx(SEL_DATA, 1'b1, 8'h00, 8'h00);
		check(w, 16'h7856);
		madr = 11'h012;
		tick();
		tick();
		check(mrd, 16'h5678);
		hx(SEL_CONTROL, 1'b0, 8'h00, 8'h00);
		hx(SEL_ADDRESS, 1'b0, 8'h00, 8'h13);
		hx(SEL_DATA, 1'b1, 8'h00, 8'h00);
		check(w, 16'h9A5E);
	endtask : s_write
	task automatic s_refuse;
		host.poke(SEL_ADDRESS, 1'b0, 8'h00);
		host.poke(SEL_ADDRESS, 1'b1, 8'h10);
		host.poke(SEL_DATA_INC, 1'b1, 8'hEE);
		hx(SEL_ADDRESS, 1'b1, 8'h00, 8'h00);
		check(w, 16'h0010);
		check({15'h0, wt}, 16'h0000);
		hx(SEL_DATA, 1'b1, 8'h00, 8'h00);
		check(w, 16'h1234);
	endtask : s_refuse
	initial begin
		repeat (8) tick();
		reset_in = 1'b0;
		repeat (4) tick();
		s_control();
		s_memory();
		s_write();
		s_refuse();
		results();
	end
endmodule : host_port_tb_top
